// *** rapc_regs.sv ***
// Purpose: rch analog power override, pump mode and halt detector bank
// Assumes: single MCLK domain, plain strobe register port
// Notes: reads answer the cycle after the strobe, unmapped reads give 0
// Notes on behaviour
// - Override bit 7 at 0x27 hands gain power to software, reset 0
// - Override bit 6 hands the analog mute control to software
// - Override bit 5 hands the dummy mute control to software
// - Override bit 3 hands offset calibration power to software
// - Override bit 2 hands short protection power to software
// - Override bit 1 hands impedance sense power to software
// - Override bit 0 hands whole-down impedance sense power over
// - Bit 4 at 0x28 requests current DAC power, 1 up, reset 0
// - Bit 3 at 0x28 requests line driver power, 1 up
// - Bit 2 at 0x28 requests line bias power, 1 up
// - Bit 1 at 0x28 requests common-mode feedback power, 1 up
// - Bit 0 at 0x28 requests output stage power, 1 up
// - Bit 7 at 0x29 requests gain control power, 1 up, reset 0
// - Bits 6 and 5 at 0x29 request mute and dummy mute power
// - Bits 3 and 2 at 0x29 request offset cal and short protection
// - Bits 1 and 0 at 0x29 request impedance sense, normal and whole
// - Bit 4 at 0x2A enables register pump mode select, reset 0
// - Bit 0 at 0x2A selects constant current pump mode, reset 1
// - Bit 4 at 0x2B powers the halt detector, reset 1
// - Bit 1 at 0x2B selects four-times detector current, reset 0
// - Bit 0 at 0x2B disables detector, output then forced to one
`timescale 1ns/1ps
`include "rapc_map.svh"
module rapc_regs (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire rapc_pkg::rapc_byte_t ADDR,
  input wire rapc_pkg::rapc_byte_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output rapc_pkg::rapc_byte_t RDATA,
  input wire logic [6:0] SEQ_OVR_PWR,
  input wire logic [4:0] SEQ_LINE_PWR,
  input wire logic PUMP_SEQ_CC,
  input wire logic HALT_DET_RAW,
  output logic [6:0] OVR_PWR,
  output logic [4:0] LINE_PWR,
  output logic PUMP_CONST_CURRENT,
  output logic HALT_DET_POWER,
  output logic HALT_DET_QUAD,
  output logic HALT_DET_OUT
);
  import rapc_pkg::*;

  logic rst_n;
  rapc_byte_t rch_power_override;
  rapc_byte_t rch_line_power_state;
  rapc_byte_t rch_aux_power_state;
  rapc_byte_t charge_pump_mode;
  rapc_byte_t clock_halt_detector_ctrl;
  rapc_reg_t wsel;
  rapc_reg_t rsel;
  logic [6:0] ovr_vec;
  logic [6:0] aux_req;
  logic [4:0] line_req;
  logic halt_raw_s1;
  logic halt_raw_s2;

  // Offset decode, shared by the write and read paths
  function automatic rapc_reg_t decode(input rapc_byte_t a);
    case (a)
      `RAPC_OFF_OVR: decode = RAPC_R_OVR;
      `RAPC_OFF_LINE: decode = RAPC_R_LINE;
      `RAPC_OFF_AUX: decode = RAPC_R_AUX;
      `RAPC_OFF_PUMP: decode = RAPC_R_PUMP;
      `RAPC_OFF_HALT: decode = RAPC_R_HALT;
      default: decode = RAPC_R_NONE;
    endcase
  endfunction : decode

  rapc_sync u_sync (
    .clk(MCLK),
    .rst_in_n(RST_N),
    .rst_out_n(rst_n)
  );

  assign wsel = decode(ADDR);
  assign rsel = decode(ADDR);

  // Override register; all eight bits stored, bit 4 reserved
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rch_power_override <= `RAPC_RST_OVR;
    end else if (WR && wsel == RAPC_R_OVR) begin
      rch_power_override <= WDATA;
    end
  end

  // Line-driver state register, reserved top bits kept
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rch_line_power_state <= `RAPC_RST_LINE;
    end else if (WR && wsel == RAPC_R_LINE) begin
      rch_line_power_state <= WDATA;
    end
  end

  // Auxiliary state register
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rch_aux_power_state <= `RAPC_RST_AUX;
    end else if (WR && wsel == RAPC_R_AUX) begin
      rch_aux_power_state <= WDATA;
    end
  end

  // Pump mode register, constant current bit set out of reset but select disabled, so sequencer drives the mode
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      charge_pump_mode <= `RAPC_RST_PUMP;
    end else if (WR && wsel == RAPC_R_PUMP) begin
      charge_pump_mode <= WDATA;
    end
  end

  // Halt detector register, powered but enabled out of reset
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      clock_halt_detector_ctrl <= `RAPC_RST_HALT;
    end else if (WR && wsel == RAPC_R_HALT) begin
      clock_halt_detector_ctrl <= WDATA;
    end
  end

  // Read data only in the cycle after the strobe; zero otherwise
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      unique case (rsel)
        RAPC_R_OVR: RDATA <= rch_power_override;
        RAPC_R_LINE: RDATA <= rch_line_power_state;
        RAPC_R_AUX: RDATA <= rch_aux_power_state;
        RAPC_R_PUMP: RDATA <= charge_pump_mode;
        RAPC_R_HALT: RDATA <= clock_halt_detector_ctrl;
        RAPC_R_NONE: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Gather override and request bits in a fixed sub-block order
  assign ovr_vec = {rch_power_override[`RAPC_BIT_GAIN],
                    rch_power_override[`RAPC_BIT_MUTE],
                    rch_power_override[`RAPC_BIT_DMUTE],
                    rch_power_override[`RAPC_BIT_OFFCAL],
                    rch_power_override[`RAPC_BIT_SHORT],
                    rch_power_override[`RAPC_BIT_IMPS],
                    rch_power_override[`RAPC_BIT_IMPW]};
  assign aux_req = {rch_aux_power_state[`RAPC_BIT_GAIN],
                    rch_aux_power_state[`RAPC_BIT_MUTE],
                    rch_aux_power_state[`RAPC_BIT_DMUTE],
                    rch_aux_power_state[`RAPC_BIT_OFFCAL],
                    rch_aux_power_state[`RAPC_BIT_SHORT],
                    rch_aux_power_state[`RAPC_BIT_IMPS],
                    rch_aux_power_state[`RAPC_BIT_IMPW]};
  assign line_req = {rch_line_power_state[`RAPC_BIT_DAC],
                     rch_line_power_state[`RAPC_BIT_LDRV],
                     rch_line_power_state[`RAPC_BIT_LBIAS],
                     rch_line_power_state[`RAPC_BIT_CMFB],
                     rch_line_power_state[`RAPC_BIT_OSTG]};

  // Per sub-block selector between sequencer and register request
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_aux
      rapc_mux u_mux (
        .ovr(ovr_vec[gi]),
        .req(aux_req[gi]),
        .seq(SEQ_OVR_PWR[gi]),
        .pwr(OVR_PWR[gi])
      );
    end
  endgenerate

  // Line blocks have their overrides elsewhere; requests pass through
  assign LINE_PWR = line_req;

  // Register mode select wins only while enabled
  assign PUMP_CONST_CURRENT =
    charge_pump_mode[`RAPC_BIT_PSEL_EN] ?
    charge_pump_mode[`RAPC_BIT_PSEL_CC] : PUMP_SEQ_CC;

  assign HALT_DET_POWER = clock_halt_detector_ctrl[`RAPC_BIT_HPWR];
  assign HALT_DET_QUAD = clock_halt_detector_ctrl[`RAPC_BIT_HQUAD];

  // Detector output comes from another domain, so sync it first
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      halt_raw_s1 <= 1'b1;
      halt_raw_s2 <= 1'b1;
    end else begin
      halt_raw_s1 <= HALT_DET_RAW;
      halt_raw_s2 <= halt_raw_s1;
    end
  end

  // Disabled detector reads as a one regardless of its raw state
  assign HALT_DET_OUT =
    clock_halt_detector_ctrl[`RAPC_BIT_HDIS] | halt_raw_s2;

  a_ovr_reset: assert property (@(posedge MCLK) $rose(rst_n) |->
    rch_power_override == 8'h00 && rch_aux_power_state == 8'h00)
    else $error("override bank not zero after reset");
  a_ovr_mute: assert property (@(posedge MCLK) disable iff (!rst_n)
    rch_power_override[6] |-> OVR_PWR[5] == rch_aux_power_state[6])
    else $error("mute override does not follow request");
  a_ovr_dmute: assert property (@(posedge MCLK) disable iff (!rst_n)
    !rch_power_override[5] |-> OVR_PWR[4] == SEQ_OVR_PWR[4])
    else $error("dummy mute not on sequencer");
  a_ovr_gain: assert property (@(posedge MCLK) disable iff (!rst_n)
    rch_power_override[7] |-> OVR_PWR[6] == rch_aux_power_state[7])
    else $error("gain override does not follow request");
  a_ovr_write: assert property (@(posedge MCLK) disable iff (!rst_n)
    WR && ADDR == 8'h27 |=> rch_power_override == $past(WDATA))
    else $error("override write lost");
  a_line_write: assert property (@(posedge MCLK) disable iff (!rst_n)
    WR && ADDR == 8'h28 |=> LINE_PWR == $past(WDATA[4:0]))
    else $error("line request not driven");
  a_pump_sel: assert property (@(posedge MCLK) disable iff (!rst_n)
    charge_pump_mode[4] |-> PUMP_CONST_CURRENT == charge_pump_mode[0])
    else $error("pump mode select ignored");
  a_pump_reset: assert property (@(posedge MCLK) $rose(rst_n) |->
    charge_pump_mode == 8'h01 && clock_halt_detector_ctrl == 8'h10)
    else $error("pump or detector reset value wrong");
  a_halt_pwr: assert property (@(posedge MCLK) disable iff (!rst_n)
    WR && ADDR == 8'h2B |=> HALT_DET_POWER == $past(WDATA[4]) &&
    HALT_DET_QUAD == $past(WDATA[1]))
    else $error("detector power or current wrong");
  a_halt_dis: assert property (@(posedge MCLK) disable iff (!rst_n)
    clock_halt_detector_ctrl[0] |-> HALT_DET_OUT)
    else $error("disabled detector output not one");
  a_read_back: assert property (@(posedge MCLK) disable iff (!rst_n)
    RD && ADDR == 8'h29 ##1 !WR [*2] |-> ##0
    $past(RDATA) == rch_aux_power_state)
    else $error("aux read back wrong");

  c_ovr_on: cover property (@(posedge MCLK) disable iff (!rst_n)
    $rose(rch_power_override[7]));
  c_pump_reg: cover property (@(posedge MCLK) disable iff (!rst_n)
    $rose(charge_pump_mode[4]));
  c_halt_off: cover property (@(posedge MCLK) disable iff (!rst_n)
    $rose(clock_halt_detector_ctrl[0]));
endmodule : rapc_regs

// *** rapc_map.svh ***
// Purpose: offsets, field positions and reset values of the rch power bank
// Assumes: byte-wide registers at their printed offsets
// Notes: definitions only
`ifndef RAPC_MAP_SVH
`define RAPC_MAP_SVH
`define RAPC_OFF_OVR 8'h27
`define RAPC_OFF_LINE 8'h28
`define RAPC_OFF_AUX 8'h29
`define RAPC_OFF_PUMP 8'h2A
`define RAPC_OFF_HALT 8'h2B
`define RAPC_RST_OVR 8'h00
`define RAPC_RST_LINE 8'h00
`define RAPC_RST_AUX 8'h00
`define RAPC_RST_PUMP 8'h01
`define RAPC_RST_HALT 8'h10
`define RAPC_BIT_GAIN 7
`define RAPC_BIT_MUTE 6
`define RAPC_BIT_DMUTE 5
`define RAPC_BIT_DAC 4
`define RAPC_BIT_OFFCAL 3
`define RAPC_BIT_SHORT 2
`define RAPC_BIT_IMPS 1
`define RAPC_BIT_IMPW 0
`define RAPC_BIT_LDRV 3
`define RAPC_BIT_LBIAS 2
`define RAPC_BIT_CMFB 1
`define RAPC_BIT_OSTG 0
`define RAPC_BIT_PSEL_EN 4
`define RAPC_BIT_PSEL_CC 0
`define RAPC_BIT_HPWR 4
`define RAPC_BIT_HQUAD 1
`define RAPC_BIT_HDIS 0
`endif

// *** rapc_pkg.sv ***
// Purpose: shared types of the rch power bank
// Assumes: nothing
// Notes: register index enumeration
package rapc_pkg;
  typedef logic [7:0] rapc_byte_t;
  typedef enum logic [2:0] {
    RAPC_R_OVR = 3'h0,
    RAPC_R_LINE = 3'h1,
    RAPC_R_AUX = 3'h2,
    RAPC_R_PUMP = 3'h3,
    RAPC_R_HALT = 3'h4,
    RAPC_R_NONE = 3'h7
  } rapc_reg_t;
endpackage : rapc_pkg

// *** rapc_sync.sv ***
// Purpose: reset release synchroniser
// Assumes: asynchronous active-low reset in
// Notes: output deasserts two edges after release
`timescale 1ns/1ps
module rapc_sync (
  input wire logic clk,
  input wire logic rst_in_n,
  output logic rst_out_n
);
  logic stage1;

  // Two flops keep release metastability off the bank
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      stage1 <= 1'b0;
      rst_out_n <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      rst_out_n <= stage1;
    end
  end
endmodule : rapc_sync

// *** rapc_mux.sv ***
// Purpose: one power control chosen between sequencer and register
// Assumes: all inputs on MCLK
// Notes: generic per sub-block selector
`timescale 1ns/1ps
module rapc_mux (
  input wire logic ovr,
  input wire logic req,
  input wire logic seq,
  output logic pwr
);
  // Override hands the power line to the register bit
  assign pwr = ovr ? req : seq;
endmodule : rapc_mux

// *** rapc_regs_tb.sv ***
// Purpose: self-checking bench for the rch power bank
// Assumes: strobe register port, outputs settle 1 ns after MCLK rise
// Notes: tasks start on a rising edge and return 1 ns after one
`timescale 1ns/1ps
`include "rapc_map.svh"
module rapc_regs_tb;
  import rapc_pkg::*;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  rapc_byte_t ADDR = 8'h00;
  rapc_byte_t WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  rapc_byte_t RDATA;
  logic [6:0] SEQ_OVR_PWR = 7'h00;
  logic [4:0] SEQ_LINE_PWR = 5'h00;
  logic PUMP_SEQ_CC = 1'b0;
  logic HALT_DET_RAW = 1'b0;
  logic [6:0] OVR_PWR;
  logic [4:0] LINE_PWR;
  logic PUMP_CONST_CURRENT, HALT_DET_POWER, HALT_DET_QUAD, HALT_DET_OUT;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  rapc_byte_t o;
  // Reset values written from the field tables, not from the map
  rapc_byte_t offs [5] = '{`RAPC_OFF_OVR, `RAPC_OFF_LINE, `RAPC_OFF_AUX,
    `RAPC_OFF_PUMP, `RAPC_OFF_HALT};
  rapc_byte_t rsts [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h10};

  rapc_regs rapc_regs_inst (
    .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SEQ_OVR_PWR(SEQ_OVR_PWR),
    .SEQ_LINE_PWR(SEQ_LINE_PWR), .PUMP_SEQ_CC(PUMP_SEQ_CC),
    .HALT_DET_RAW(HALT_DET_RAW), .OVR_PWR(OVR_PWR), .LINE_PWR(LINE_PWR),
    .PUMP_CONST_CURRENT(PUMP_CONST_CURRENT),
    .HALT_DET_POWER(HALT_DET_POWER), .HALT_DET_QUAD(HALT_DET_QUAD),
    .HALT_DET_OUT(HALT_DET_OUT)
  );

  // 10 MHz control clock
  always #50 MCLK = ~MCLK;

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input rapc_byte_t got, input rapc_byte_t exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : tick

  // Reset held four cycles; first access waits three edges past release
  task automatic do_reset();
    @(posedge MCLK);
    RST_N <= 1'b0;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    tick(3);
  endtask : do_reset

  task automatic wr(input rapc_byte_t a, input rapc_byte_t d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    #1;
  endtask : wr

  // Read data stand one cycle only, then return to zero
  task automatic rd(input rapc_byte_t a, input rapc_byte_t exp);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
    tick(1);
    chk(RDATA, 8'h00);
  endtask : rd

  task automatic set_in(input logic [6:0] s, input logic cc, input logic raw);
    @(posedge MCLK);
    SEQ_OVR_PWR <= s;
    PUMP_SEQ_CC <= cc;
    HALT_DET_RAW <= raw;
    #1;
  endtask : set_in

  // Sub-block order on the power outputs, reserved bit 4 dropped
  function automatic logic [6:0] pick(input rapc_byte_t r);
    return {r[7:5], r[3:0]};
  endfunction : pick

  initial begin
    do_reset();
    // Reset values, then again after a reset in mid-run
    for (int k = 0; k < 2; k++) begin
      for (int r = 0; r < 5; r++) rd(offs[r], rsts[r]);
      chk({3'h0, LINE_PWR}, 8'h00);
      chk({6'h0, HALT_DET_POWER, HALT_DET_QUAD}, 8'h02);
      for (int r = 0; r < 5; r++) wr(offs[r], 8'hA5);
      for (int r = 0; r < 5; r++) rd(offs[r], 8'hA5);
      do_reset();
    end
    // Unmapped places neither store nor answer
    wr(8'h26, 8'hFF);
    wr(8'h2C, 8'hFF);
    rd(8'h26, 8'h00);
    rd(8'h2C, 8'h00);
    rd(`RAPC_OFF_OVR, 8'h00);
    // Each override bit alone, state all up then sequencer all up
    for (int i = 0; i < 8; i++) begin
      o = 8'h01 << i;
      wr(`RAPC_OFF_OVR, o);
      wr(`RAPC_OFF_AUX, 8'hFF);
      set_in(7'h00, 1'b0, 1'b0);
      chk({1'b0, OVR_PWR}, {1'b0, pick(o)});
      wr(`RAPC_OFF_AUX, 8'h00);
      set_in(7'h7F, 1'b0, 1'b0);
      chk({1'b0, OVR_PWR}, {1'b0, ~pick(o)});
      rd(`RAPC_OFF_OVR, o);
    end
    // Line requests one bit at a time, reserved bits have no effect
    for (int i = 0; i < 8; i++) begin
      o = 8'h01 << i;
      wr(`RAPC_OFF_LINE, o);
      chk({3'h0, LINE_PWR}, (i < 5) ? o : 8'h00);
    end
    // Pump mode: sequencer while disabled, register once enabled
    wr(`RAPC_OFF_PUMP, 8'h01);
    set_in(7'h00, 1'b1, 1'b0);
    chk({7'h0, PUMP_CONST_CURRENT}, 8'h01);
    set_in(7'h00, 1'b0, 1'b0);
    chk({7'h0, PUMP_CONST_CURRENT}, 8'h00);
    wr(`RAPC_OFF_PUMP, 8'h11);
    chk({7'h0, PUMP_CONST_CURRENT}, 8'h01);
    wr(`RAPC_OFF_PUMP, 8'h10);
    set_in(7'h00, 1'b1, 1'b0);
    chk({7'h0, PUMP_CONST_CURRENT}, 8'h00);
    // Halt detector power, current and output forcing
    wr(`RAPC_OFF_HALT, 8'h00);
    tick(3);
    chk({5'h0, HALT_DET_POWER, HALT_DET_QUAD, HALT_DET_OUT}, 8'h00);
    wr(`RAPC_OFF_HALT, 8'h12);
    set_in(7'h00, 1'b0, 1'b1);
    tick(1);
    chk({7'h0, HALT_DET_OUT}, 8'h00);
    tick(1);
    chk({5'h0, HALT_DET_POWER, HALT_DET_QUAD, HALT_DET_OUT}, 8'h07);
    set_in(7'h00, 1'b0, 1'b0);
    tick(3);
    chk({7'h0, HALT_DET_OUT}, 8'h00);
    wr(`RAPC_OFF_HALT, 8'h01);
    chk({5'h0, HALT_DET_POWER, HALT_DET_QUAD, HALT_DET_OUT}, 8'h01);
    conclude();
  end
endmodule : rapc_regs_tb
